// file: sim/rsrt_link_sva.sv
// assertion checker for the rc trim link and device status
`timescale 1ns/1ps
module rsrt_link_sva #(
  parameter logic [15:0] RCO_DEFAULT_HALF = 16'h0ee6
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link pins
  input wire logic csel,
  input wire logic sclk,
  input wire logic oscIn,
  // device status
  input wire logic timebase,
  input wire logic rcoOn,
  input wire logic trimValid,
  input wire logic [15:0] rcoHalfPeriod,
  input wire logic clockSourceSelect,
  input wire logic powerDown
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic sclkQ;
  logic [6:0] riseCnt;
  // rising sclk count per frame, cleared while deselected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkQ <= 1'b0;
      riseCnt <= 7'h00;
    end else begin
      sclkQ <= sclk;
      if (!csel) riseCnt <= 7'h00;
      else if (sclk && !sclkQ) riseCnt <= riseCnt + 7'h01;
    end
  end
  // frame end and rc stop conditions
  sequence frame_end;
    $fell(csel);
  endsequence
  sequence rc_stopped;
    (powerDown || clockSourceSelect) [*3];
  endsequence
  chk_rc_off: assert property (rc_stopped |-> !rcoOn)
    else $error("rc running while stopped");
  chk_rc_on: assert property ((!powerDown && !clockSourceSelect) [*3] |-> rcoOn)
    else $error("rc not running");
  chk_trim_lost: assert property (!rcoOn |-> ##1 (!trimValid && rcoHalfPeriod == RCO_DEFAULT_HALF))
    else $error("trim kept after rc off");
  chk_trim_edge: assert property ($rose(trimValid) |-> csel && riseCnt == 7'h49)
    else $error("trim applied off the last edge");
  chk_sclk_framed: assert property ($rose(sclk) |-> csel)
    else $error("sclk outside frame");
  chk_frame_count: assert property (frame_end |-> (riseCnt == 7'h10 || riseCnt == 7'h49))
    else $error("wrong edge count in frame");
  chk_csel_gap: assert property (frame_end |-> !csel [*8])
    else $error("frame gap too short");
  chk_sclk_idle: assert property (!csel |-> !sclk)
    else $error("sclk high while idle");
  chk_osc_pdown: assert property ($rose(powerDown) |-> oscIn [*8])
    else $error("oscillator pin moving in power down");
  chk_tb_pdown: assert property (powerDown [*3] |-> !timebase)
    else $error("time base running in power down");
endmodule : rsrt_link_sva

// file: sim/tb_rtc_source_and_rc_trim.sv
// self-checking bench for host and device across the link
`timescale 1ns/1ps
module tb_rtc_source_and_rc_trim;
  // short untrimmed half period keeps rc checks quick
  localparam logic [15:0] DEF_HALF = 16'h0014;
  // short reference half period keeps a full calibration within the cycle budget
  localparam logic [15:0] REF_HALF = 16'h0064;
  logic clk;
  logic rst_n;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timebase;
  logic rcoOn;
  logic trimValid;
  logic [15:0] rcoHalfPeriod;
  logic clockSourceSelect;
  logic powerDown;
  logic [31:0] rd;
  logic err;
  int errors;
  int n_compared;
  int n;
  rsrt_link_if link ();
  rsrt_host #(.REF_HALF_M1(REF_HALF - 16'h0001)) u_rsrt_host (.clk(clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.host));
  rsrt_device #(.RCO_DEFAULT_HALF(DEF_HALF)) u_rsrt_device (.clk(clk), .rst_n(rst_n), .link(link.dev),
    .timebase(timebase), .rcoOn(rcoOn), .trimValid(trimValid), .rcoHalfPeriod(rcoHalfPeriod),
    .clockSourceSelect(clockSourceSelect), .powerDown(powerDown));
  rsrt_link_sva #(.RCO_DEFAULT_HALF(DEF_HALF)) u_rsrt_link_sva (.clk(clk), .rst_n(rst_n),
    .csel(link.csel), .sclk(link.sclk), .oscIn(link.oscIn), .timebase(timebase), .rcoOn(rcoOn),
    .trimValid(trimValid), .rcoHalfPeriod(rcoHalfPeriod), .clockSourceSelect(clockSourceSelect),
    .powerDown(powerDown));
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 50) errors++;
  endtask : apb
  task automatic wait_sig(ref logic s, input logic v, input int lim);
    int i;
    i = 0;
    while (s !== v && i < lim) begin
      @(posedge clk);
      i++;
    end
    check({31'h0, s}, {31'h0, v});
  endtask : wait_sig
  // counts level changes of a signal over a span
  task automatic count_edges(ref logic s, input int cyc, output int cnt);
    logic q;
    cnt = 0;
    q = s;
    repeat (cyc) begin
      @(posedge clk);
      if (s !== q) cnt++;
      q = s;
    end
  endtask : count_edges
  task automatic t_reset;
    repeat (4) @(posedge clk);
    check({31'h0, rcoOn}, 32'h1);
    check({16'h0, rcoHalfPeriod}, {16'h0, DEF_HALF});
    check({31'h0, trimValid}, 32'h0);
    check({30'h0, link.csel, link.oscIn}, 32'h1);
    apb(rsrt_pkg::OFF_CHAN, 1'b0, 32'h0);
    check(rd, 32'h7);
  endtask : t_reset
  // channel writes: refused combinations leave the register alone
  task automatic t_chan;
    logic [4:0] val [7];
    logic bad [7];
    val = '{5'h0d, 5'h0b, 5'h12, 5'h11, 5'h15, 5'h0f, 5'h18};
    bad = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    for (int i = 0; i < 7; i++) begin
      apb(rsrt_pkg::OFF_CHAN, 1'b1, {27'h0, val[i]});
      check({31'h0, err}, {31'h0, bad[i]});
    end
    apb(rsrt_pkg::OFF_CHAN, 1'b0, 32'h0);
    check(rd, 32'h0f);
    apb(12'h010, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
  endtask : t_chan
  // full calibration: 64 reference periods measured, half = acc >> 7
  task automatic t_trim;
    int i;
    apb(rsrt_pkg::OFF_CTRL, 1'b1, 32'h1);
    check({31'h0, trimValid}, 32'h0);
    wait_sig(trimValid, 1'b1, 20000);
    check({16'h0, rcoHalfPeriod}, (64 * 2 * {16'h0, REF_HALF}) >> 7);
    i = 0;
    do begin
      apb(rsrt_pkg::OFF_STAT, 1'b0, 32'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 300);
    check({24'h0, rd[9:2]}, 32'h1);
  endtask : t_trim
  // crystal select stops rc and loses the trim
  task automatic t_rc_lost;
    apb(rsrt_pkg::OFF_CFG, 1'b1, 32'h1);
    wait_sig(clockSourceSelect, 1'b1, 8000);
    repeat (8) @(posedge clk);
    check({31'h0, rcoOn}, 32'h0);
    check({15'h0, trimValid, rcoHalfPeriod}, {16'h0, DEF_HALF});
  endtask : t_rc_lost
  // external clock alone must still select the pin path; rc would toggle far faster
  task automatic t_ext;
    apb(rsrt_pkg::OFF_CFG, 1'b1, 32'h4);
    repeat (8000) @(posedge clk);
    count_edges(timebase, 2000, n);
    check({31'h0, n >= 16 && n <= 24}, 32'h1);
  endtask : t_ext
  task automatic t_pdown;
    apb(rsrt_pkg::OFF_CFG, 1'b1, 32'h7);
    wait_sig(powerDown, 1'b1, 8000);
    count_edges(link.oscIn, 9000, n);
    check(n, 0);
    check({30'h0, link.oscIn, timebase}, 32'h2);
    check({31'h0, rcoOn}, 32'h0);
  endtask : t_pdown
  // rc back on untrimmed, time base follows it
  task automatic t_rc_back;
    apb(rsrt_pkg::OFF_CFG, 1'b1, 32'h0);
    wait_sig(powerDown, 1'b0, 8000);
    repeat (8) @(posedge clk);
    check({31'h0, rcoOn}, 32'h1);
    check({15'h0, trimValid, rcoHalfPeriod}, {16'h0, DEF_HALF});
    count_edges(timebase, 400, n);
    check({31'h0, n >= 16}, 32'h1);
  endtask : t_rc_back
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  // watchdog sized for one calibration plus the short scenarios
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    give_verdict();
  end
  initial begin
    errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_chan();
    t_trim();
    t_rc_lost();
    t_ext();
    t_pdown();
    t_rc_back();
    give_verdict();
  end
endmodule : tb_rtc_source_and_rc_trim

// file: verilog/rsrt_device.sv
// device end: serial receiver, rc trim and time base select
`timescale 1ns/1ps
module rsrt_device #(
  parameter logic [15:0] RCO_DEFAULT_HALF = rsrt_pkg::RCO_DEFAULT_HALF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to host
  rsrt_link_if.dev link,
  // user side status
  output logic timebase,
  output logic rcoOn,
  output logic trimValid,
  output logic [15:0] rcoHalfPeriod,
  output logic clockSourceSelect,
  output logic powerDown
);
  rsrt_pkg::rsrt_dev_state_e state;
  logic [3:0] syncA, syncB, prevB;
  logic [7:0] shreg;
  logic [2:0] bitCnt;
  logic [5:0] addr;
  logic [6:0] edgeCnt;
  logic [23:0] acc;
  logic [7:0] cfgReg;
  logic [15:0] rcoCnt;
  logic rcoClk;
  logic csHigh, sckRise, dataBit, oscLvl;
  logic [7:0] nextByte;
  logic byteDone, trimApply;

  // two-stage sync on every pin, third stage only for edge finding
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
      prevB <= 4'h0;
    end else begin
      syncA <= {link.csel, link.sclk, link.sdata, link.oscIn};
      syncB <= syncA;
      prevB <= syncB;
    end
  end

  assign csHigh = syncB[3];
  assign sckRise = syncB[2] & ~prevB[2];
  assign dataBit = syncB[1];
  assign oscLvl = syncB[0];
  assign nextByte = {shreg[6:0], dataBit};
  assign byteDone = sckRise && (bitCnt == 3'h7);
  assign trimApply = (state == rsrt_pkg::DEV_TRIM) && csHigh && sckRise &&
                     (edgeCnt == rsrt_pkg::TRIM_EDGES - 7'h01);

  // frame decoder; chip select low always returns to idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rsrt_pkg::DEV_IDLE;
      shreg <= 8'h00;
      bitCnt <= 3'h0;
      addr <= 6'h00;
    end else if (!csHigh) begin
      state <= rsrt_pkg::DEV_IDLE;
      bitCnt <= 3'h0;
    end else begin
      if (sckRise && (state == rsrt_pkg::DEV_CMD || state == rsrt_pkg::DEV_DATA)) begin
        shreg <= nextByte;
        bitCnt <= bitCnt + 3'h1;
      end
      unique case (state)
        rsrt_pkg::DEV_IDLE: begin
          state <= rsrt_pkg::DEV_CMD;
        end
        rsrt_pkg::DEV_CMD: begin
          if (byteDone) begin
            if (nextByte == {rsrt_pkg::MODE_DIRECT, rsrt_pkg::TRIM_CODE}) begin
              state <= rsrt_pkg::DEV_TRIM; // R2
            end else if (nextByte[7:6] == rsrt_pkg::MODE_WRITE) begin
              addr <= nextByte[5:0];
              state <= rsrt_pkg::DEV_DATA;
            end else begin
              state <= rsrt_pkg::DEV_WAIT;
            end
          end
        end
        rsrt_pkg::DEV_DATA: begin
          if (byteDone) begin
            state <= rsrt_pkg::DEV_WAIT;
          end
        end
        rsrt_pkg::DEV_TRIM: begin
          if (trimApply) begin
            state <= rsrt_pkg::DEV_WAIT;
          end
        end
        rsrt_pkg::DEV_WAIT: begin
          state <= rsrt_pkg::DEV_WAIT;
        end
      endcase
    end
  end

  // configuration byte written by a write frame to the config address
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReg <= rsrt_pkg::DEV_CFG_RESET;
    end else if (csHigh && state == rsrt_pkg::DEV_DATA && byteDone && addr == rsrt_pkg::CFG_ADDR) begin
      cfgReg <= nextByte;
    end
  end

  // reference edges after the command; clk cycles counted from the first edge on
  // counting the first edge's cycle too, else 64 periods read one short and truncate low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edgeCnt <= 7'h00;
      acc <= 24'h000000;
    end else if (state != rsrt_pkg::DEV_TRIM) begin
      edgeCnt <= 7'h00;
      acc <= 24'h000000;
    end else begin
      if (sckRise) begin
        edgeCnt <= edgeCnt + 7'h01;
      end
      if ((edgeCnt != 7'h00 || sckRise) && acc != 24'hffffff) begin
        acc <= acc + 24'h000001;
      end
    end
  end

  // rc runs only when selected and not powered down
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcoOn <= 1'b0;
      clockSourceSelect <= 1'b0;
      powerDown <= 1'b0;
    end else begin
      rcoOn <= ~cfgReg[rsrt_pkg::CFG_PDOWN_BIT] & ~cfgReg[rsrt_pkg::CFG_CLKSEL_BIT]; // R3
      clockSourceSelect <= cfgReg[rsrt_pkg::CFG_CLKSEL_BIT];
      powerDown <= cfgReg[rsrt_pkg::CFG_PDOWN_BIT];
    end
  end

  // trim is volatile: lost whenever the rc stops, back to untrimmed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcoHalfPeriod <= RCO_DEFAULT_HALF;
      trimValid <= 1'b0;
    end else if (!rcoOn) begin
      rcoHalfPeriod <= RCO_DEFAULT_HALF; // R8 R15
      trimValid <= 1'b0; // R8
    end else if (trimApply) begin
      rcoHalfPeriod <= acc[22:7]; // R7
      trimValid <= 1'b1;
    end
  end

  // behavioural rc oscillator; 64 reference periods span 128 half periods
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rcoCnt <= 16'h0000;
      rcoClk <= 1'b0;
    end else if (!rcoOn) begin
      rcoCnt <= 16'h0000;
      rcoClk <= 1'b0;
    end else if (rcoCnt + 16'h0001 >= rcoHalfPeriod) begin
      rcoCnt <= 16'h0000;
      rcoClk <= ~rcoClk;
    end else begin
      rcoCnt <= rcoCnt + 16'h0001;
    end
  end

  // time base: oscillator pin path or rc
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timebase <= 1'b0;
    end else if (cfgReg[rsrt_pkg::CFG_CLKSEL_BIT]) begin
      timebase <= oscLvl & ~cfgReg[rsrt_pkg::CFG_PDOWN_BIT]; // R1
    end else begin
      timebase <= rcoClk; // R1
    end
  end
endmodule : rsrt_device

// file: verilog/rsrt_host.sv
// host end: apb registers, serial frames, calibration reference, external clock
//
// Notes on behaviour
// R1: device timebase from oscillator pin when bit set
// R2: calibration starts only on trim command
// R3: rc off in power down or crystal
// R4: chip select high before trim command
// R5: exactly 65 reference periods, select high
// R6: chip select low after reference periods
// R7: new trim applies at 65th edge
// R8: trim volatile; recalibrate after rc off
// R9: external clock needs clock source bit set
// R10: oscillator pin held high in power down
// R11: two channels in low power: 1, 3
// R12: on/off single channel must be channel 1
// R13: never both low power modes together
// R14: reference near quarter of carrier frequency
// R15: untrimmed rc until next calibration
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rsrt_host #(
  // reference half period minus one, in clk cycles
  parameter logic [15:0] REF_HALF_M1 = rsrt_pkg::REF_HALF_M1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link to device
  rsrt_link_if.host link
);
  rsrt_pkg::rsrt_host_state_e state;
  logic [2:0] cfgReg;
  logic [4:0] chanReg;
  logic trimPend, cfgPend, trimMode;
  logic [7:0] trimCount;
  logic [15:0] shreg;
  logic [4:0] bitsLeft;
  logic [6:0] edges;
  logic [15:0] sckCnt, refCnt;
  logic refClk;
  logic csel, sclk, sdata, oscIn;
  logic sckTick, refTick;
  logic setupPh, wrEn, busy;
  logic chanBad, unmapped;
  logic [1:0] enCount;
  logic [7:0] cfgByte;
  logic takeTrim, takeCfg;

  assign link.csel = csel;
  assign link.sclk = sclk;
  assign link.sdata = sdata;
  assign link.oscIn = oscIn;

  // apb phase decode
  assign setupPh = psel & ~penable;
  assign wrEn = psel & penable & pready & pwrite & ~pslverr;
  assign busy = (state != rsrt_pkg::HST_IDLE);
  assign unmapped = !(paddr == rsrt_pkg::OFF_CTRL || paddr == rsrt_pkg::OFF_CFG ||
                      paddr == rsrt_pkg::OFF_CHAN || paddr == rsrt_pkg::OFF_STAT);
  assign enCount = 2'(pwdata[0]) + 2'(pwdata[1]) + 2'(pwdata[2]);

  // illegal channel setups are refused
  always_comb begin
    chanBad = 1'b0;
    if (pwdata[rsrt_pkg::CHAN_SCAN_BIT] && pwdata[rsrt_pkg::CHAN_ONOFF_BIT]) begin
      chanBad = 1'b1; // R13
    end
    if ((pwdata[rsrt_pkg::CHAN_SCAN_BIT] || pwdata[rsrt_pkg::CHAN_ONOFF_BIT]) && enCount == 2'h2 &&
        pwdata[2:0] != rsrt_pkg::CHAN_PAIR) begin
      chanBad = 1'b1; // R11
    end
    if (pwdata[rsrt_pkg::CHAN_ONOFF_BIT] && enCount == 2'h1 && pwdata[2:0] != rsrt_pkg::CHAN_SINGLE) begin
      chanBad = 1'b1; // R12
    end
  end

  // one wait-free access phase; answer prepared in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setupPh;
      pslverr <= setupPh & (unmapped | (pwrite & paddr == rsrt_pkg::OFF_CHAN & chanBad));
      prdata <= 32'h00000000;
      if (setupPh && !pwrite) begin
        unique case (paddr)
          rsrt_pkg::OFF_CFG: prdata <= {29'h0, cfgReg};
          rsrt_pkg::OFF_CHAN: prdata <= {27'h0, chanReg};
          rsrt_pkg::OFF_STAT: prdata <= {22'h0, trimCount, trimPend | cfgPend, busy};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReg <= rsrt_pkg::HOST_CFG_RESET;
      chanReg <= rsrt_pkg::CHAN_RESET;
    end else if (wrEn) begin
      if (paddr == rsrt_pkg::OFF_CFG) begin
        cfgReg <= pwdata[2:0];
      end
      if (paddr == rsrt_pkg::OFF_CHAN) begin
        chanReg <= pwdata[4:0];
      end
    end
  end

  // pending requests; a new request wins over being taken
  // taking only on a bit tick keeps select low a full bit half between frames
  assign takeTrim = (state == rsrt_pkg::HST_IDLE) && sckTick && trimPend;
  assign takeCfg = (state == rsrt_pkg::HST_IDLE) && sckTick && !trimPend && cfgPend;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trimPend <= 1'b0;
      cfgPend <= 1'b0;
    end else begin
      if (wrEn && paddr == rsrt_pkg::OFF_CTRL && pwdata[0]) begin
        trimPend <= 1'b1;
      end else if (takeTrim) begin
        trimPend <= 1'b0;
      end
      if (wrEn && paddr == rsrt_pkg::OFF_CFG) begin
        cfgPend <= 1'b1;
      end else if (takeCfg) begin
        cfgPend <= 1'b0;
      end
    end
  end

  // external clock needs the oscillator path selected
  assign cfgByte = {5'h00, cfgReg[rsrt_pkg::CFG_EXTCLK_BIT], cfgReg[rsrt_pkg::CFG_PDOWN_BIT],
                    cfgReg[rsrt_pkg::CFG_CLKSEL_BIT] | cfgReg[rsrt_pkg::CFG_EXTCLK_BIT]}; // R9

  // free running bit clock and reference dividers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sckCnt <= 16'h0000;
      refCnt <= 16'h0000;
      refClk <= 1'b0;
    end else begin
      sckCnt <= (sckCnt == 16'h0000) ? rsrt_pkg::SCK_HALF_M1 : sckCnt - 16'h0001;
      if (refCnt == 16'h0000) begin
        refCnt <= REF_HALF_M1; // R14
        refClk <= ~refClk;
      end else begin
        refCnt <= refCnt - 16'h0001;
      end
    end
  end
  assign sckTick = (sckCnt == 16'h0000);
  assign refTick = (refCnt == 16'h0000);

  // oscillator pin: reference when external clock used outside power down, else parked high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oscIn <= 1'b1;
    end else if (cfgReg[rsrt_pkg::CFG_EXTCLK_BIT] && !cfgReg[rsrt_pkg::CFG_PDOWN_BIT]) begin
      oscIn <= ~refClk;
    end else begin
      oscIn <= 1'b1; // R10
    end
  end

  // link sequencer; data changes on falling sclk, device samples rising
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= rsrt_pkg::HST_IDLE;
      csel <= 1'b0;
      sclk <= 1'b0;
      sdata <= 1'b0;
      shreg <= 16'h0000;
      bitsLeft <= 5'h00;
      edges <= 7'h00;
      trimMode <= 1'b0;
      trimCount <= 8'h00;
    end else begin
      unique case (state)
        rsrt_pkg::HST_IDLE: begin
          sclk <= 1'b0;
          if (takeTrim) begin
            shreg <= {rsrt_pkg::MODE_DIRECT, rsrt_pkg::TRIM_CODE, 8'h00};
            bitsLeft <= rsrt_pkg::CMD_BITS;
            trimMode <= 1'b1;
            csel <= 1'b1; // R4
            state <= rsrt_pkg::HST_SETUP;
          end else if (takeCfg) begin
            shreg <= {rsrt_pkg::MODE_WRITE, rsrt_pkg::CFG_ADDR, cfgByte};
            bitsLeft <= rsrt_pkg::WRITE_BITS;
            trimMode <= 1'b0;
            csel <= 1'b1;
            state <= rsrt_pkg::HST_SETUP;
          end
        end
        rsrt_pkg::HST_SETUP: begin
          sdata <= shreg[15];
          if (sckTick) begin
            state <= rsrt_pkg::HST_SHIFT;
          end
        end
        rsrt_pkg::HST_SHIFT: begin
          if (sckTick && !sclk) begin
            sclk <= 1'b1;
          end else if (sckTick) begin
            sclk <= 1'b0;
            shreg <= {shreg[14:0], 1'b0};
            sdata <= shreg[14];
            bitsLeft <= bitsLeft - 5'h01;
            if (bitsLeft == 5'h01) begin
              edges <= 7'h00;
              state <= trimMode ? rsrt_pkg::HST_REF : rsrt_pkg::HST_FINISH;
            end
          end
        end
        rsrt_pkg::HST_REF: begin
          if (refTick && !sclk) begin
            sclk <= 1'b1;
            edges <= edges + 7'h01; // R5
          end else if (refTick) begin
            sclk <= 1'b0;
            if (edges == rsrt_pkg::TRIM_EDGES) begin
              state <= rsrt_pkg::HST_FINISH; // R5
            end
          end
        end
        rsrt_pkg::HST_FINISH: begin
          if (sckTick) begin
            csel <= 1'b0; // R6
            sdata <= 1'b0;
            if (trimMode) begin
              trimCount <= trimCount + 8'h01;
            end
            state <= rsrt_pkg::HST_IDLE;
          end
        end
      endcase
    end
  end
endmodule : rsrt_host

// file: verilog/rsrt_link_if.sv
// serial link and oscillator pin between host and device
`timescale 1ns/1ps
interface rsrt_link_if;
  logic csel;
  logic sclk;
  logic sdata;
  logic oscIn;
  modport host (output csel, output sclk, output sdata, output oscIn);
  modport dev (input csel, input sclk, input sdata, input oscIn);
endinterface : rsrt_link_if

// file: verilog/rsrt_pkg.sv
// shared constants and types for the rtc source and rc trim link
package rsrt_pkg;
  // system clock
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint PS_PER_S = 64'd1000000000000;
  // reference clock for calibration and external clock
  localparam int REF_FREQ_HZ = 32768;
  localparam int REF_HALF_CYC = int'(PS_PER_S / (2 * REF_FREQ_HZ * CLK_PERIOD_PS));
  localparam logic [15:0] REF_HALF_M1 = 16'(REF_HALF_CYC - 1);
  // serial bit clock while shifting commands
  localparam int SCK_PERIOD_NS = 1000;
  localparam int SCK_HALF_CYC = (SCK_PERIOD_NS * 1000) / (2 * CLK_PERIOD_PS);
  localparam logic [15:0] SCK_HALF_M1 = 16'(SCK_HALF_CYC - 1);
  // untrimmed rc half period, nominal 32768 Hz
  localparam logic [15:0] RCO_DEFAULT_HALF = 16'(REF_HALF_CYC);
  // serial frame layout
  localparam logic [1:0] MODE_WRITE = 2'h0;
  localparam logic [1:0] MODE_DIRECT = 2'h3;
  localparam logic [5:0] TRIM_CODE = 6'h02;
  localparam logic [5:0] CFG_ADDR = 6'h01;
  localparam logic [4:0] CMD_BITS = 5'h08;
  localparam logic [4:0] WRITE_BITS = 5'h10;
  localparam logic [6:0] TRIM_EDGES = 7'h41;
  // device configuration byte fields
  localparam int CFG_CLKSEL_BIT = 0;
  localparam int CFG_PDOWN_BIT = 1;
  localparam int CFG_EXTCLK_BIT = 2;
  localparam logic [7:0] DEV_CFG_RESET = 8'h00;
  // host apb register offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_CFG = 12'h004;
  localparam logic [11:0] OFF_CHAN = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00c;
  // host channel register fields
  localparam int CHAN_SCAN_BIT = 3;
  localparam int CHAN_ONOFF_BIT = 4;
  localparam logic [2:0] CHAN_PAIR = 3'h5;
  localparam logic [2:0] CHAN_SINGLE = 3'h1;
  localparam logic [2:0] HOST_CFG_RESET = 3'h0;
  localparam logic [4:0] CHAN_RESET = 5'h07;
  // device receive states
  typedef enum logic [4:0] {
    DEV_IDLE = 5'b00001,
    DEV_CMD = 5'b00010,
    DEV_DATA = 5'b00100,
    DEV_TRIM = 5'b01000,
    DEV_WAIT = 5'b10000
  } rsrt_dev_state_e;
  // host transmit states
  typedef enum logic [4:0] {
    HST_IDLE = 5'b00001,
    HST_SETUP = 5'b00010,
    HST_SHIFT = 5'b00100,
    HST_REF = 5'b01000,
    HST_FINISH = 5'b10000
  } rsrt_host_state_e;
endpackage : rsrt_pkg
